/* core/crtc_defs.svh */
// Offsets, field positions, reset values and timing counts
`ifndef CRTC_DEFS_SVH
`define CRTC_DEFS_SVH
// Host I/O locations of the two ports
`define IO_INDEX_ADDR 8'h68
`define IO_DATA_ADDR 8'h6a
// Control register numbers
`define IX_HTOTAL 5'h00
`define IX_HSHOWN 5'h01
`define IX_HPLACE 5'h02
`define IX_HWIDTH 5'h03
`define IX_VTOTAL 5'h04
`define IX_VEXTRA 5'h05
`define IX_VSHOWN 5'h06
`define IX_VPLACE 5'h07
`define IX_INTERLEAVE 5'h08
`define IX_LINES 5'h09
`define IX_CUR_TOP 5'h0a
`define IX_CUR_BOT 5'h0b
`define IX_ORG_HI 5'h0c
`define IX_ORG_LO 5'h0d
`define IX_CUR_HI 5'h0e
`define IX_CUR_LO 5'h0f
`define IX_PEN_HI 5'h10
`define IX_PEN_LO 5'h11
`define IX_LAST 5'h11
// Scan mode codes
`define MODE_PLAIN 2'h0
`define MODE_INTERLACE 2'h1
`define MODE_SPLIT 2'h3
// Cursor field positions
`define CUR_ROW_MSB 4
`define CUR_MODE_LSB 6
// Blink counter bits for 1/16 and 1/32 of field rate
`define BLINK16_BIT 3
`define BLINK32_BIT 4
// Vertical sync length in scan lines
`define VSYNC_LINES 8'h10
// Controller APB map
`define APB_CMD 12'h000
`define APB_STATUS 12'h004
`define APB_CTRL 12'h008
// Command word fields
`define CMD_SEL_BIT 8
`define CMD_READ_BIT 9
// Reset value of the register file
`define REG_RESET 8'h00
`endif

/* core/crtc_pkg.sv */
// Types for the two ends of the display timing link: bus states for the controller, cursor modes for the device
package crtc_pkg;
  typedef enum logic [3:0] {
    BUS_IDLE = 4'h1,
    BUS_SETUP = 4'h2,
    BUS_STROBE = 4'h4,
    BUS_HOLD = 4'h8
  } bus_state_t;
  typedef enum logic [1:0] {
    CUR_STEADY = 2'h0,
    CUR_HIDDEN = 2'h1,
    CUR_BLINK16 = 2'h2,
    CUR_BLINK32 = 2'h3
  } cursor_mode_t;
endpackage

/* core/crtc_if.sv */
// Host bus, counter clear, pen and video pins between controller and device
`timescale 1ns/1ps
interface crtc_if;
  logic cs_n;
  logic index_select;
  logic rw;
  logic bus_strobe;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic counter_clear_n;
  logic pen_strobe;
  logic hsync;
  logic vsync;
  logic display_window;
  logic cursor_out;
  logic [13:0] refresh_addr_out;
  logic [4:0] cell_line_out;
  modport dev (
    input cs_n, index_select, rw, bus_strobe, wdata, counter_clear_n,
    input pen_strobe,
    output rdata, hsync, vsync, display_window, cursor_out,
    output refresh_addr_out, cell_line_out
  );
  modport host (
    output cs_n, index_select, rw, bus_strobe, wdata, counter_clear_n,
    output pen_strobe,
    input rdata, hsync, vsync, display_window, cursor_out,
    input refresh_addr_out, cell_line_out
  );
endinterface

/* core/crtc_device.sv */
// Raster display timing device with indexed register file
//
// Contract
// - Write-only 5-bit index pointer selects register
// - Host loads pointer with register number
// - Host writes index first, then data
// - Select low is pointer, high is data
// - Transfer only with chip select; rw high reads
// - Horizontal total is line length minus one
// - Horizontal shown sets displayed characters
// - Horizontal place starts horizontal sync
// - Horizontal width sets sync length
// - Vertical total rows minus one; extra lines
// - Vertical shown sets displayed rows
// - Vertical place starts vertical sync row
// - Mode 00 plain, 01 interlace, 03 split
// - Lines per row holds count minus one
// - Cursor top low five bits give row
// - Cursor bits 7:6 steady, hidden, blink rates
// - Host keeps cursor bottom not below top
// - Frame origin pair forms 14-bit start
// - Cursor location pair 14-bit, read and write
// - Address equals cursor, cursor high one clock
// - Pen rising edge captures refresh address
// - Clear input zeroes counters, outputs low
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "crtc_defs.svh"
module crtc_device (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link to the controller
  crtc_if.dev link
);
  ////////////////////////////////////////////////////////////////////////
  // Register file
  logic [4:0] index_ff;
  logic [7:0] regs_ff [0:17];
  logic [7:0] rdata_ff;
  logic [13:0] pen_ff;
  logic [13:0] ma_ff;

  wire bus_on = link.bus_strobe && !link.cs_n;
  wire wr_index = bus_on && !link.rw && !link.index_select;
  wire wr_data = bus_on && !link.rw && link.index_select;
  wire rd_data = bus_on && link.rw && link.index_select;
  // Pen registers are read-only; indices past the last are ignored
  wire wr_ok = wr_data && index_ff < `IX_PEN_HI;

  function automatic logic [7:0] read_mux(input logic [4:0] ix,
                                          input logic [13:0] cur,
                                          input logic [13:0] pen);
    case (ix)
      `IX_CUR_HI: read_mux = {2'b00, cur[13:8]};
      `IX_CUR_LO: read_mux = cur[7:0];
      `IX_PEN_HI: read_mux = {2'b00, pen[13:8]};
      `IX_PEN_LO: read_mux = pen[7:0];
      default: read_mux = 8'h00;
    endcase
  endfunction

  wire [13:0] origin = {regs_ff[`IX_ORG_HI][5:0], regs_ff[`IX_ORG_LO]};
  wire [13:0] cur_loc = {regs_ff[`IX_CUR_HI][5:0], regs_ff[`IX_CUR_LO]};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      index_ff <= 5'h00;
    end else if (wr_index) begin
      index_ff <= link.wdata[4:0];
    end
  end

  // Registers keep their contents under the counter clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i <= 17; i++) begin
        regs_ff[i] <= `REG_RESET;
      end
    end else if (wr_ok) begin
      regs_ff[index_ff] <= link.wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= 8'h00;
    end else if (rd_data) begin
      rdata_ff <= read_mux(index_ff, cur_loc, pen_ff);
    end
  end
  assign link.rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // Pen strobe synchroniser and capture
  logic pen_s1_ff;
  logic pen_s2_ff;
  logic pen_s3_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pen_s1_ff <= 1'b0;
      pen_s2_ff <= 1'b0;
      pen_s3_ff <= 1'b0;
      pen_ff <= 14'h0000;
    end else begin
      pen_s1_ff <= link.pen_strobe;
      pen_s2_ff <= pen_s1_ff;
      pen_s3_ff <= pen_s2_ff;
      if (pen_s2_ff && !pen_s3_ff) begin
        pen_ff <= ma_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Raster counters
  logic [7:0] hc_ff;
  logic [7:0] hsw_ff;
  logic [7:0] row_ff;
  logic [4:0] line_ff;
  logic [7:0] extra_ff;
  logic [7:0] vsw_ff;
  logic in_extra_ff;
  logic field_ff;
  logic [4:0] blink_ff;
  logic [13:0] row_base_ff;
  logic hsync_ff;
  logic vsync_ff;
  logic window_ff;
  logic cursor_ff;

  wire clr = !link.counter_clear_n;
  wire [1:0] mode = regs_ff[`IX_INTERLEAVE][1:0];
  wire split = mode == `MODE_SPLIT;
  wire interlaced = mode[0];
  wire [4:0] max_line = regs_ff[`IX_LINES][4:0];
  wire [4:0] step = split ? 5'h02 : 5'h01;
  wire [4:0] first_line = split ? {4'h0, field_ff} : 5'h00;
  wire line_end = hc_ff == regs_ff[`IX_HTOTAL];
  wire row_last_line = ({1'b0, line_ff} + {1'b0, step}) >
                       {1'b0, max_line};
  wire rows_done = row_ff == regs_ff[`IX_VTOTAL];
  wire extra_done = extra_ff == regs_ff[`IX_VEXTRA];
  wire field_end = in_extra_ff ? extra_done :
                   (rows_done && row_last_line &&
                    regs_ff[`IX_VEXTRA] == 8'h00);
  wire [7:0] hc_next = hc_ff + 8'h01;
  wire [13:0] ma_next = row_base_ff + {6'h00, hc_next};
  wire hs_start = hc_ff == regs_ff[`IX_HPLACE];
  wire vs_start = line_end && !in_extra_ff && row_last_line &&
                  (row_ff + 8'h01) == regs_ff[`IX_VPLACE];
  wire shown = hc_next < regs_ff[`IX_HSHOWN] &&
               row_ff < regs_ff[`IX_VSHOWN] && !in_extra_ff;
  // Row that the next line belongs to, judged before the counters move
  wire next_row_shown = field_end ? regs_ff[`IX_VSHOWN] != 8'h00 :
                        in_extra_ff ? 1'b0 :
                        (row_last_line && rows_done) ? 1'b0 :
                        row_last_line ?
                        (row_ff + 8'h01) < regs_ff[`IX_VSHOWN] :
                        row_ff < regs_ff[`IX_VSHOWN];
  wire [7:0] cur_top = {3'h0, regs_ff[`IX_CUR_TOP][`CUR_ROW_MSB:0]};
  wire [7:0] cur_bot = {3'h0, regs_ff[`IX_CUR_BOT][`CUR_ROW_MSB:0]};
  wire [1:0] cur_mode = regs_ff[`IX_CUR_TOP][7:`CUR_MODE_LSB];
  wire blink_on = cur_mode == crtc_pkg::CUR_STEADY ||
                  (cur_mode == crtc_pkg::CUR_BLINK16 &&
                   blink_ff[`BLINK16_BIT]) ||
                  (cur_mode == crtc_pkg::CUR_BLINK32 &&
                   blink_ff[`BLINK32_BIT]);
  // Bottom below top leaves the cursor dark
  wire in_rows = {3'h0, line_ff} >= cur_top &&
                 {3'h0, line_ff} <= cur_bot;

  // Horizontal position, sync and refresh address
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hc_ff <= 8'h00;
      hsw_ff <= 8'h00;
      hsync_ff <= 1'b0;
      ma_ff <= 14'h0000;
    end else if (clr) begin
      hc_ff <= 8'h00;
      hsw_ff <= 8'h00;
      hsync_ff <= 1'b0;
      ma_ff <= 14'h0000;
    end else begin
      hc_ff <= line_end ? 8'h00 : hc_next;
      if (hs_start && regs_ff[`IX_HWIDTH] != 8'h00) begin
        hsync_ff <= 1'b1;
        hsw_ff <= regs_ff[`IX_HWIDTH] - 8'h01;
      end else if (hsw_ff != 8'h00) begin
        hsw_ff <= hsw_ff - 8'h01;
      end else begin
        hsync_ff <= 1'b0;
      end
      if (!line_end) begin
        ma_ff <= ma_next;
      end else if (field_end) begin
        ma_ff <= origin;
      end else if (row_last_line && !in_extra_ff) begin
        ma_ff <= row_base_ff + {6'h00, regs_ff[`IX_HSHOWN]};
      end else begin
        ma_ff <= row_base_ff;
      end
    end
  end

  // Vertical position, fields and blink timing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      row_ff <= 8'h00;
      line_ff <= 5'h00;
      extra_ff <= 8'h00;
      in_extra_ff <= 1'b0;
      field_ff <= 1'b0;
      blink_ff <= 5'h00;
      row_base_ff <= 14'h0000;
      vsw_ff <= 8'h00;
      vsync_ff <= 1'b0;
    end else if (clr) begin
      row_ff <= 8'h00;
      line_ff <= 5'h00;
      extra_ff <= 8'h00;
      in_extra_ff <= 1'b0;
      field_ff <= 1'b0;
      blink_ff <= 5'h00;
      // First field after a clear starts at the frame origin too
      row_base_ff <= origin;
      vsw_ff <= 8'h00;
      vsync_ff <= 1'b0;
    end else if (line_end) begin
      if (vs_start) begin
        vsync_ff <= 1'b1;
        vsw_ff <= `VSYNC_LINES - 8'h01;
      end else if (vsw_ff != 8'h00) begin
        vsw_ff <= vsw_ff - 8'h01;
      end else begin
        vsync_ff <= 1'b0;
      end
      if (field_end) begin
        row_ff <= 8'h00;
        extra_ff <= 8'h00;
        in_extra_ff <= 1'b0;
        field_ff <= interlaced ? !field_ff : 1'b0;
        line_ff <= (split && !field_ff) ? 5'h01 : 5'h00;
        blink_ff <= blink_ff + 5'h01;
        row_base_ff <= origin;
      end else if (in_extra_ff) begin
        extra_ff <= extra_ff + 8'h01;
      end else if (row_last_line) begin
        line_ff <= first_line;
        row_base_ff <= row_base_ff + {6'h00, regs_ff[`IX_HSHOWN]};
        if (rows_done) begin
          in_extra_ff <= 1'b1;
          extra_ff <= 8'h01;
        end else begin
          row_ff <= row_ff + 8'h01;
        end
      end else begin
        line_ff <= line_ff + step;
      end
    end
  end

  // Window and cursor outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      window_ff <= 1'b0;
      cursor_ff <= 1'b0;
    end else if (clr) begin
      window_ff <= 1'b0;
      cursor_ff <= 1'b0;
    end else begin
      window_ff <= line_end ? (regs_ff[`IX_HSHOWN] != 8'h00 &&
                               next_row_shown) :
                   shown;
      cursor_ff <= ma_next == cur_loc && !line_end && shown &&
                   blink_on && in_rows;
    end
  end

  assign link.hsync = hsync_ff;
  assign link.vsync = vsync_ff;
  assign link.display_window = window_ff;
  assign link.cursor_out = cursor_ff;
  assign link.refresh_addr_out = ma_ff;
  assign link.cell_line_out = clr ? 5'h00 : line_ff;
endmodule

/* core/crtc_host.sv */
// Controller end: APB register slave driving the device host bus
`timescale 1ns/1ps
`include "crtc_defs.svh"
module crtc_host (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link to the device
  crtc_if.host link
);
  crtc_pkg::bus_state_t state_ff;
  crtc_pkg::bus_state_t nxt_state;
  logic sel_ff;
  logic rw_ff;
  logic [7:0] wdata_ff;
  logic [7:0] last_rd_ff;
  logic clear_n_ff;
  logic pen_ff;
  logic [31:0] prdata_ff;

  wire busy = state_ff != crtc_pkg::BUS_IDLE;
  wire acc = psel && penable;
  wire hit_cmd = paddr == `APB_CMD;
  wire hit_sts = paddr == `APB_STATUS;
  wire hit_ctl = paddr == `APB_CTRL;
  wire mapped = hit_cmd || hit_sts || hit_ctl;
  // Command writes stall while a bus transfer is running
  wire stall = pwrite && hit_cmd && busy;
  wire cmd_go = acc && pwrite && hit_cmd && !busy;
  wire ctl_go = acc && pwrite && hit_ctl;
  wire [31:0] rd_mux = hit_sts ? {16'h0000, last_rd_ff, 7'h00, busy} :
                       hit_ctl ? {30'h0, pen_ff, clear_n_ff} : 32'h0;

  assign pready = !stall;
  assign pslverr = acc && !mapped;
  assign prdata = prdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // Host bus sequencer
  always_comb begin
    case (state_ff)
      crtc_pkg::BUS_IDLE: nxt_state = cmd_go ? crtc_pkg::BUS_SETUP :
                                               crtc_pkg::BUS_IDLE;
      crtc_pkg::BUS_SETUP: nxt_state = crtc_pkg::BUS_STROBE;
      crtc_pkg::BUS_STROBE: nxt_state = crtc_pkg::BUS_HOLD;
      crtc_pkg::BUS_HOLD: nxt_state = crtc_pkg::BUS_IDLE;
      default: nxt_state = crtc_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= crtc_pkg::BUS_IDLE;
      sel_ff <= 1'b0;
      rw_ff <= 1'b0;
      wdata_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      if (cmd_go) begin
        sel_ff <= pwdata[`CMD_SEL_BIT];
        rw_ff <= pwdata[`CMD_READ_BIT];
        wdata_ff <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_rd_ff <= 8'h00;
      clear_n_ff <= 1'b0;
      pen_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      if (state_ff == crtc_pkg::BUS_HOLD && rw_ff) begin
        last_rd_ff <= link.rdata;
      end
      if (ctl_go) begin
        clear_n_ff <= pwdata[0];
        pen_ff <= pwdata[1];
      end
      if (psel && !penable && !pwrite) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  wire active = state_ff == crtc_pkg::BUS_SETUP ||
                state_ff == crtc_pkg::BUS_STROBE;
  assign link.cs_n = !active;
  assign link.index_select = sel_ff;
  assign link.rw = rw_ff;
  assign link.wdata = wdata_ff;
  assign link.bus_strobe = state_ff == crtc_pkg::BUS_STROBE;
  assign link.counter_clear_n = clear_n_ff;
  assign link.pen_strobe = pen_ff;
endmodule

/* dv/crtc_link_monitor.sv */
// Checker for the link between the controller and the timing device
`timescale 1ns/1ps
module crtc_link_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Host bus and control
  input wire logic cs_n,
  input wire logic index_select,
  input wire logic rw,
  input wire logic bus_strobe,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic counter_clear_n,
  input wire logic pen_strobe,
  // Video
  input wire logic hsync,
  input wire logic vsync,
  input wire logic display_window,
  input wire logic cursor_out,
  input wire logic [13:0] refresh_addr_out,
  input wire logic [4:0] cell_line_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [4:0] idx_ff;
  logic [7:0] htot_ff, hwid_ff, cur_hi_ff, cur_lo_ff;
  logic [15:0] hs_cnt_ff, vs_cnt_ff, hp_cnt_ff;
  logic hs_q_ff, armed_ff;
  wire take = bus_strobe && !cs_n;
  wire rd_take = take && rw;
  wire wr_data = take && !rw && index_select;
  wire [7:0] exp_rd = idx_ff == 5'h0e ? {2'h0, cur_hi_ff[5:0]} :
    idx_ff == 5'h0f ? cur_lo_ff : 8'h00;
  wire [15:0] line_len = {8'h00, htot_ff} + 16'h0001;
  ////////////////////////////////////////////////////////////////////////
  // Shadow of the register file and pulse counters
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idx_ff <= 5'h00;
      htot_ff <= 8'h00;
      hwid_ff <= 8'h00;
      cur_hi_ff <= 8'h00;
      cur_lo_ff <= 8'h00;
    end else begin
      if (take && !rw && !index_select) idx_ff <= wdata[4:0];
      if (wr_data && idx_ff == 5'h00) htot_ff <= wdata;
      if (wr_data && idx_ff == 5'h03) hwid_ff <= wdata;
      if (wr_data && idx_ff == 5'h0e) cur_hi_ff <= wdata;
      if (wr_data && idx_ff == 5'h0f) cur_lo_ff <= wdata;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hs_cnt_ff <= 16'h0000;
      vs_cnt_ff <= 16'h0000;
      hp_cnt_ff <= 16'h0000;
      hs_q_ff <= 1'b0;
      armed_ff <= 1'b0;
    end else if (!counter_clear_n) begin
      hs_cnt_ff <= 16'h0000;
      vs_cnt_ff <= 16'h0000;
      hp_cnt_ff <= 16'h0000;
      hs_q_ff <= 1'b0;
      armed_ff <= 1'b0;
    end else begin
      hs_cnt_ff <= hsync ? hs_cnt_ff + 16'h0001 : 16'h0000;
      vs_cnt_ff <= vsync ? vs_cnt_ff + 16'h0001 : 16'h0000;
      hp_cnt_ff <= (hsync && !hs_q_ff) ? 16'h0001 : hp_cnt_ff + 16'h0001;
      hs_q_ff <= hsync;
      armed_ff <= armed_ff || (hsync && !hs_q_ff);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  a_strobe_needs_select: assert property (bus_strobe |-> !cs_n)
    else $error("strobe without chip select");
  a_clear_outputs_low: assert property ($past(!counter_clear_n) |->
    !hsync && !vsync && !display_window && !cursor_out &&
    refresh_addr_out == 14'h0000 && cell_line_out == 5'h00)
    else $error("outputs not low while cleared");
  a_cursor_one_clock: assert property (cursor_out |=> !cursor_out)
    else $error("cursor pulse longer than one clock");
  a_rdata_only_reads: assert property (
    !$past(rd_take) |-> $stable(rdata))
    else $error("read data changed without a read");
  a_read_value: assert property (rd_take && index_select &&
    idx_ff != 5'h10 && idx_ff != 5'h11 |=> rdata == $past(exp_rd))
    else $error("read data wrong for index");
  a_hsync_width: assert property (
    disable iff (!nrst || !counter_clear_n)
    $fell(hsync) |-> hs_cnt_ff == {8'h00, hwid_ff})
    else $error("horizontal pulse width wrong");
  a_line_period: assert property (
    disable iff (!nrst || !counter_clear_n)
    $rose(hsync) && armed_ff |-> hp_cnt_ff == line_len)
    else $error("line period wrong");
  a_vsync_length: assert property (
    disable iff (!nrst || !counter_clear_n)
    $fell(vsync) |-> vs_cnt_ff == line_len << 4)
    else $error("vertical pulse length wrong");
  c_cursor: cover property ($rose(cursor_out));
  c_vsync: cover property ($fell(vsync));
  c_read: cover property (rd_take && index_select);
  c_pen: cover property ($rose(pen_strobe) && counter_clear_n);
endmodule

/* dv/crtc_timing_controller_tb_top.sv */
// Self-checking bench for controller and device joined by the link
`timescale 1ns/1ps
`include "crtc_defs.svh"
module crtc_timing_controller_tb_top;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [7:0] v;
  logic [13:0] pen;
  int num_errors, total_checks;
  crtc_if crtc_if_i ();
  crtc_host crtc_host_i (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(crtc_if_i));
  crtc_device crtc_device_i (.clk(clk), .nrst(nrst), .link(crtc_if_i));
  crtc_link_monitor crtc_link_monitor_i (.clk(clk), .nrst(nrst),
    .cs_n(crtc_if_i.cs_n), .index_select(crtc_if_i.index_select),
    .rw(crtc_if_i.rw), .bus_strobe(crtc_if_i.bus_strobe),
    .wdata(crtc_if_i.wdata), .rdata(crtc_if_i.rdata),
    .counter_clear_n(crtc_if_i.counter_clear_n),
    .pen_strobe(crtc_if_i.pen_strobe), .hsync(crtc_if_i.hsync),
    .vsync(crtc_if_i.vsync), .display_window(crtc_if_i.display_window),
    .cursor_out(crtc_if_i.cursor_out),
    .refresh_addr_out(crtc_if_i.refresh_addr_out),
    .cell_line_out(crtc_if_i.cell_line_out));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic reg_wr(input logic [4:0] idx, input logic [7:0] d);
    apb(1'b1, `APB_CMD, {27'h0, idx});
    apb(1'b1, `APB_CMD, {23'h0, 1'b1, d});
  endtask
  task automatic reg_rd(input logic [4:0] idx);
    int n;
    n = 0;
    apb(1'b1, `APB_CMD, {27'h0, idx});
    apb(1'b1, `APB_CMD, {22'h0, 2'h3, 8'h00});
    do begin
      apb(1'b0, `APB_STATUS, 32'h0);
      n++;
    end while (rv[0] !== 1'b0 && n < 20);
    v = rv[15:8];
  endtask
  task automatic frames(input logic [7:0] mode, input logic [1:0] cm,
      input int exp_cur);
    logic vq;
    int t0, nwin, ncur, nvs, ncyc;
    vq = 1'b0;
    t0 = 0;
    nwin = 0;
    ncur = 0;
    nvs = 0;
    ncyc = 0;
    reg_wr(`IX_INTERLEAVE, mode);
    reg_wr(`IX_CUR_TOP, {cm, 6'h00});
    apb(1'b1, `APB_CTRL, 32'h1);
    while (nvs < 32 && ncyc < 20000) begin
      @(posedge clk);
      ncyc++;
      if (crtc_if_i.display_window === 1'b1) nwin++;
      if (crtc_if_i.cursor_out === 1'b1) ncur++;
      if (crtc_if_i.vsync === 1'b1 && !vq) begin
        nvs++;
        if (nvs == 1) t0 = ncyc;
      end
      vq = crtc_if_i.vsync === 1'b1;
    end
    check("cursor pulses", exp_cur, ncur);
    if (mode != 8'h03) begin
      // First cell after a clear is dark: outputs were held low
      check("window cycles", 32 * 48 - 1, nwin);
      check("field period", 31 * 330, ncyc - t0);
    end
    apb(1'b1, `APB_CTRL, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    summarize();
  end
  initial begin
    logic [7:0] prog [14];
    prog = '{8'h09, 8'h06, 8'h07, 8'h02, 8'h07, 8'h01, 8'h02, 8'h03,
      8'h00, 8'h03, 8'h00, 8'h00, 8'h01, 8'h30};
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, 12'h00c, 32'h0);
    check("unmapped error", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rv);
    reg_wr(`IX_CUR_HI, 8'hff);
    reg_wr(`IX_CUR_LO, 8'ha5);
    reg_rd(`IX_CUR_HI);
    check("cursor high", 32'h3f, {24'h0, v});
    reg_rd(`IX_CUR_LO);
    check("cursor low", 32'ha5, {24'h0, v});
    reg_wr(`IX_HTOTAL, 8'h5a);
    reg_rd(`IX_HTOTAL);
    check("write-only read", 32'h0, {24'h0, v});
    reg_wr(`IX_PEN_LO, 8'h55);
    reg_rd(`IX_PEN_LO);
    check("pen write ignored", 32'h0, {24'h0, v});
    for (int i = 0; i < 14; i++) begin
      reg_wr(i[4:0], prog[i]);
    end
    reg_wr(`IX_CUR_HI, 8'h01);
    reg_wr(`IX_CUR_LO, 8'h32);
    frames(8'h00, 2'h0, 32);
    frames(8'h00, 2'h1, 0);
    frames(8'h00, 2'h2, 16);
    frames(8'h00, 2'h3, 16);
    frames(8'h01, 2'h0, 32);
    frames(8'h03, 2'h0, 16);
    reg_rd(`IX_CUR_LO);
    check("kept over clear", 32'h32, {24'h0, v});
    apb(1'b1, `APB_CTRL, 32'h1);
    repeat (150) @(posedge clk);
    apb(1'b1, `APB_CTRL, 32'h3);
    repeat (5) @(posedge clk);
    reg_rd(`IX_PEN_HI);
    pen[13:8] = v[5:0];
    reg_rd(`IX_PEN_LO);
    pen[7:0] = v;
    check("pen in frame", 32'h1, {31'h0, pen >= 14'h0130 && pen < 14'h0170});
    summarize();
  end
endmodule
